// ==== core/pic_consts.svh ====
// constant macros for the priority interrupt controller
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
`define PIC_NSRC          14
`define PIC_VEC_NMI       8'h07
`define PIC_VEC_CH3_A     8'h24
`define PIC_VEC_CH3_B     8'h25
`define PIC_VEC_CH3_W     8'h26
`define PIC_VEC_CH4_A     8'h28
`define PIC_VEC_CH4_B     8'h29
`define PIC_VEC_CH4_W     8'h2a
`define PIC_VEC_SIO_ERR   8'h34
`define PIC_VEC_SIO_RXF   8'h35
`define PIC_VEC_SIO_TXE   8'h36
`define PIC_VEC_SIO_TXD   8'h37
`define PIC_VEC_CONV      8'h3c
`define PIC_VEC_SHIFT     2
`define PIC_ADDR_BITS     16
`define PIC_OFF_SYSCTL    8'h00
`define PIC_OFF_PRIO      8'h04
`define PIC_OFF_ENABLE    8'h08
`define PIC_OFF_CPUFLAG   8'h0c
`define PIC_OFF_STATUS    8'h10
`define PIC_BIT_MSS       0
`define PIC_BIT_NMIEDGE   1
`define PIC_BIT_GMASK     0
`define PIC_BIT_SMASK     1
`define PIC_BIT_STANDBY   2
`define PIC_BIT_B7        7
`define PIC_BIT_B6        6
`define PIC_BIT_B3        3
`define PIC_BIT_B1        1
`define PIC_RST_SYSCTL    8'h01
`define PIC_RST_PRIO      8'h00
`define PIC_RST_ENABLE    16'h0000
`define PIC_RST_CPUFLAG   8'h01
`endif

// ==== core/pic_pkg.sv ====
// types for the priority interrupt controller
package pic_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_WAIT_END, ST_PUSH_PC, ST_PUSH_CW, ST_VEC_REQ, ST_VEC_WAIT, ST_JUMP} pic_state_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
    logic [15:0] vec_addr;
  } pic_take_t;
  typedef struct packed {
    logic        retire;
    logic [31:0] pc;
    logic [7:0]  cond_word;
  } pic_cpu_t;
endpackage

// ==== core/pic_top.sv ====
// priority interrupt controller with cpu exception sequencer and ahb-lite registers
// Contract
// - ch3 requests: vectors 36-38, bit b7
// - ch4 requests: vectors 40-42, bit b6
// - serial 52-55 under b3, converter 60 b1
// - vector address is four times vector
// - nmi taken unless reset or standby
// - disabled sources are ignored
// - forward only occurred and enabled requests
// - select one by level, others pend
// - equal level ties use default order
// - scheme 1: global flag masks all maskable
// - level 1 ranks above level 0
// - scheme 0: global flag masks level 0
// - scheme 0, global only: nmi and level1
// - scheme 0, global clear: accept all
// - scheme 0, both flags: nmi only
// - start only at instruction end
// - push pc and condition word
// - scheme 1: set global flag after save
// - scheme 0: set both flags after save
// - fetch vector, run from handler address
// - smaller vector wins by default
// - nmi highest, vector 7, edge selectable
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "pic_consts.svh"
module pic_top (
  input  wire logic                 CLK,        // 250 MHz system clock
  input  wire logic                 RESET_N,    // synchronous reset, active low
  input  wire logic                 NMI_PIN,    // nonmaskable request pin
  input  wire logic [13:0]          SRC_REQ,    // module requests, vector order (ch3 a..conv)
  input  wire pic_pkg::pic_cpu_t    CPU_IN,     // cpu retire strobe, pc, condition word
  output logic                      CPU_HOLD,   // cpu stalled during exception
  output logic                      STK_WR,     // stack push strobe
  output logic [31:0]               STK_DATA,   // stack push data
  output logic                      VEC_RD,     // vector fetch request
  output pic_pkg::pic_take_t        VEC_INFO,   // accepted vector and address
  input  wire logic                 VEC_ACK,    // vector data valid
  input  wire logic [31:0]          VEC_DATA,   // handler start address
  output logic                      JUMP,       // load pc from jump target
  output logic [31:0]               JUMP_PC,    // handler start address
  input  wire logic [31:0]          HADDR,      // ahb address
  input  wire logic [1:0]           HTRANS,     // ahb transfer type
  input  wire logic                 HWRITE,     // ahb write
  input  wire logic [2:0]           HSIZE,      // ahb size
  input  wire logic [31:0]          HWDATA,     // ahb write data
  input  wire logic                 HSEL,       // ahb select
  input  wire logic                 HREADY,     // ahb bus ready
  output logic [31:0]               HRDATA,     // ahb read data
  output logic                      HREADYOUT,  // ahb slave ready
  output logic                      HRESP       // ahb response, always okay
);
  import pic_pkg::*;

  logic [7:0]  system_control_reg;
  logic [7:0]  priority_level_bits;
  logic [15:0] enable_reg;
  logic [7:0]  cpu_flag_reg;
  logic        ph_wr_reg;
  logic [31:0] ph_addr_reg;
  logic [2:0]  nmi_sync_reg;
  logic        nmi_pend_reg;
  pic_state_t  state_reg;
  pic_take_t   take_reg;
  logic [31:0] pc_save_reg;
  logic [7:0]  cw_save_reg;
  logic [31:0] hrdata_reg;

  wire mss       = system_control_reg[`PIC_BIT_MSS];
  wire nmi_rise  = system_control_reg[`PIC_BIT_NMIEDGE];
  wire gmask     = cpu_flag_reg[`PIC_BIT_GMASK];
  wire smask     = cpu_flag_reg[`PIC_BIT_SMASK];
  wire standby   = cpu_flag_reg[`PIC_BIT_STANDBY];

  // vectors and priority bits per source, in default order
  localparam logic [7:0] VEC_TAB [14] = '{`PIC_VEC_CH3_A, `PIC_VEC_CH3_B, `PIC_VEC_CH3_W,
    `PIC_VEC_CH4_A, `PIC_VEC_CH4_B, `PIC_VEC_CH4_W, `PIC_VEC_SIO_ERR, `PIC_VEC_SIO_RXF,
    `PIC_VEC_SIO_TXE, `PIC_VEC_SIO_TXD, `PIC_VEC_CONV, 8'h00, 8'h00, 8'h00};
  localparam int PBIT_TAB [14] = '{`PIC_BIT_B7, `PIC_BIT_B7, `PIC_BIT_B7, `PIC_BIT_B6, `PIC_BIT_B6,
    `PIC_BIT_B6, `PIC_BIT_B3, `PIC_BIT_B3, `PIC_BIT_B3, `PIC_BIT_B3, `PIC_BIT_B1, 0, 0, 0};

  // bus slave: zero wait states, okay always
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_reg;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 32'h0000_0000;
    end else if (HREADY) begin
      ph_wr_reg   <= HSEL && HTRANS[1] && HWRITE;
      ph_addr_reg <= HADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      unique case (HADDR[7:0])
        `PIC_OFF_SYSCTL:  hrdata_reg <= {24'h000000, system_control_reg};
        `PIC_OFF_PRIO:    hrdata_reg <= {24'h000000, priority_level_bits};
        `PIC_OFF_ENABLE:  hrdata_reg <= {16'h0000, enable_reg};
        `PIC_OFF_CPUFLAG: hrdata_reg <= {24'h000000, cpu_flag_reg};
        `PIC_OFF_STATUS:  hrdata_reg <= {16'h0000, nmi_pend_reg, state_reg, 4'h0, take_reg.vector};
        default:          hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      system_control_reg  <= `PIC_RST_SYSCTL;
      priority_level_bits <= `PIC_RST_PRIO;
      enable_reg          <= `PIC_RST_ENABLE;
    end else if (ph_wr_reg) begin
      if (ph_addr_reg[7:0] == `PIC_OFF_SYSCTL) system_control_reg <= HWDATA[7:0];
      if (ph_addr_reg[7:0] == `PIC_OFF_PRIO) priority_level_bits <= HWDATA[7:0];
      if (ph_addr_reg[7:0] == `PIC_OFF_ENABLE) enable_reg <= HWDATA[15:0];
    end
  end

  // nmi pin: three stages, change once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      nmi_sync_reg <= 3'b000;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], NMI_PIN};
    end
  end
  logic nmi_level_reg;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      nmi_level_reg <= 1'b0;
    end else if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
      nmi_level_reg <= nmi_sync_reg[2];
    end
  end
  wire nmi_edge = (nmi_sync_reg[1] == nmi_sync_reg[2]) && (nmi_sync_reg[2] != nmi_level_reg) &&
                  (nmi_sync_reg[2] == nmi_rise);
  // the vector mux picks nmi whenever it is pending, so clear on that same view
  wire nmi_taken = (state_reg == ST_WAIT_END) && CPU_IN.retire && nmi_pend_reg;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      nmi_pend_reg <= 1'b0;
    end else if (standby) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_reg <= 1'b1; // set wins over the clear
    end else if (nmi_taken) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // requests gated by enables and level-dependent masks
  logic [13:0] live;
  logic [13:0] level1;
  genvar g;
  generate
    for (g = 0; g < `PIC_NSRC; g++) begin : g_src
      wire lvl = (g < 11) ? priority_level_bits[PBIT_TAB[g]] : 1'b0;
      wire allowed = mss ? !gmask
                         : (!gmask || (lvl && !smask));
      assign level1[g] = lvl;
      assign live[g]   = (g < 11) && SRC_REQ[g] && enable_reg[g] && allowed;
    end
  endgenerate

  // level 1 group first, then default order (lowest index = smallest vector)
  logic [3:0] pick;
  logic       pick_ok;
  always_comb begin
    pick    = 4'h0;
    pick_ok = 1'b0;
    for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
      if (live[i] && level1[i]) begin
        pick    = 4'(i);
        pick_ok = 1'b1;
      end
    end
    if (!pick_ok) begin
      for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
        if (live[i]) begin
          pick    = 4'(i);
          pick_ok = 1'b1;
        end
      end
    end
  end

  wire        any_req  = nmi_pend_reg || pick_ok;
  wire [7:0]  sel_vec  = nmi_pend_reg ? `PIC_VEC_NMI : VEC_TAB[pick];
  wire [15:0] sel_addr = 16'({sel_vec, 2'b00});

  // exception sequencer
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN:      if (any_req) state_reg <= ST_WAIT_END;
        ST_WAIT_END: if (CPU_IN.retire) state_reg <= any_req ? ST_PUSH_PC : ST_RUN;
        ST_PUSH_PC:  state_reg <= ST_PUSH_CW;
        ST_PUSH_CW:  state_reg <= ST_VEC_REQ;
        ST_VEC_REQ:  state_reg <= ST_VEC_WAIT;
        ST_VEC_WAIT: if (VEC_ACK) state_reg <= ST_JUMP;
        ST_JUMP:     state_reg <= ST_RUN;
      endcase
    end
  end

  // decision re-evaluated while waiting; frozen at the instruction end
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      take_reg     <= '0;
      pc_save_reg  <= 32'h0000_0000;
      cw_save_reg  <= 8'h00;
    end else if (state_reg == ST_RUN || state_reg == ST_WAIT_END) begin
      take_reg.vector   <= sel_vec;
      take_reg.vec_addr <= sel_addr;
      take_reg.valid    <= 1'b0;
      if (state_reg == ST_WAIT_END && CPU_IN.retire) begin
        take_reg.valid <= any_req;
        pc_save_reg    <= CPU_IN.pc;
        cw_save_reg    <= CPU_IN.cond_word;
      end
    end else if (state_reg == ST_JUMP) begin
      take_reg.valid <= 1'b0;
    end
  end

  // cpu mask flags: reset masked; write from bus, set on acceptance
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cpu_flag_reg <= `PIC_RST_CPUFLAG;
    end else if (state_reg == ST_PUSH_CW) begin
      cpu_flag_reg[`PIC_BIT_GMASK] <= 1'b1;
      if (!mss) cpu_flag_reg[`PIC_BIT_SMASK] <= 1'b1;
    end else if (ph_wr_reg && ph_addr_reg[7:0] == `PIC_OFF_CPUFLAG) begin
      cpu_flag_reg <= HWDATA[7:0];
    end
  end

  // stack pushes, vector fetch, jump
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      STK_WR   <= 1'b0;
      STK_DATA <= 32'h0000_0000;
      VEC_RD   <= 1'b0;
      JUMP     <= 1'b0;
      JUMP_PC  <= 32'h0000_0000;
    end else begin
      STK_WR <= (state_reg == ST_PUSH_PC) || (state_reg == ST_PUSH_CW);
      if (state_reg == ST_PUSH_PC) STK_DATA <= pc_save_reg;
      if (state_reg == ST_PUSH_CW) STK_DATA <= {24'h000000, cw_save_reg};
      VEC_RD <= (state_reg == ST_VEC_REQ) || (state_reg == ST_VEC_WAIT && !VEC_ACK);
      JUMP   <= (state_reg == ST_VEC_WAIT) && VEC_ACK;
      if (state_reg == ST_VEC_WAIT && VEC_ACK) JUMP_PC <= VEC_DATA;
    end
  end

  assign CPU_HOLD = (state_reg != ST_RUN) && (state_reg != ST_WAIT_END);
  assign VEC_INFO = take_reg;
endmodule

// ==== test/pic_cpu_model.sv ====
// cpu core model: retires instructions and answers vector fetches
`timescale 1ns/1ns
module pic_cpu_model (
  input  wire logic               clk,      // clock
  input  wire logic               rst_n,    // reset
  input  wire logic               hold,     // stall
  input  wire logic               vec_rd,   // fetch
  input  wire pic_pkg::pic_take_t info,     // vector
  input  wire logic               jump,     // jump
  output pic_pkg::pic_cpu_t       cpu,      // cpu status
  output logic                    vec_ack,  // fetch done
  output logic [31:0]             vec_data  // handler
);
  import pic_pkg::*;
  logic [1:0] gap_reg;
  logic [1:0] wait_reg;
  logic       done_reg;
  logic       go;
  assign go = rst_n && vec_rd && !vec_ack && !done_reg && wait_reg == 2'h0;
  // one instruction ends every four cycles, never while stalled
  always_ff @(posedge clk) begin
    gap_reg <= rst_n ? gap_reg + 2'h1 : 2'h0;
    cpu.retire <= rst_n && !hold && gap_reg == 2'h3;
    cpu.pc <= !rst_n ? 32'h1000 : cpu.retire ? cpu.pc + 32'h2 : cpu.pc;
    cpu.cond_word <= !rst_n ? 8'h0f : jump ? ~cpu.cond_word : cpu.cond_word;
  end
  // answer at once or up to three cycles late; idle data lines toggle
  always_ff @(posedge clk) begin
    vec_ack <= go;
    done_reg <= rst_n && vec_rd && (done_reg || vec_ack);
    wait_reg <= !vec_rd ? cpu.pc[2:1] : wait_reg - {1'b0, wait_reg != 2'h0};
    vec_data <= !rst_n ? 32'h0 : go ? {16'h8000, info.vec_addr} : ~vec_data;
  end
endmodule

// ==== test/pic_top_checker.sv ====
// assertions on the interrupt controller ports
`timescale 1ns/1ns
module pic_top_checker (
  input wire logic               CLK,       // clock
  input wire logic               RESET_N,   // reset
  input wire pic_pkg::pic_cpu_t  CPU_IN,    // cpu status
  input wire logic               CPU_HOLD,  // stall
  input wire logic               STK_WR,    // push
  input wire logic [31:0]        STK_DATA,  // push data
  input wire logic               VEC_RD,    // fetch
  input wire pic_pkg::pic_take_t VEC_INFO,  // vector
  input wire logic               VEC_ACK,   // fetch done
  input wire logic [31:0]        VEC_DATA,  // handler
  input wire logic               JUMP,      // jump
  input wire logic [31:0]        JUMP_PC,   // target
  input wire logic               HREADYOUT, // ready
  input wire logic               HRESP      // response
);
  import pic_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_start;
    $rose(VEC_INFO.valid);
  endsequence
  sequence s_push;
    STK_WR && STK_DATA == $past(CPU_IN.pc, 2) ##1 STK_WR && STK_DATA == {24'h0, $past(CPU_IN.cond_word, 3)};
  endsequence
  AST_START: assert property (s_start |-> $past(CPU_IN.retire) && CPU_HOLD)
    else $error("sequence began off an instruction end");
  AST_PUSH: assert property (s_start |-> ##1 s_push ##1 VEC_RD)
    else $error("wrong stack pushes");
  AST_VADDR: assert property (VEC_INFO.valid |-> VEC_INFO.vec_addr == {6'h00, VEC_INFO.vector, 2'b00})
    else $error("vector address not four times vector");
  AST_VSET: assert property (VEC_INFO.valid |-> VEC_INFO.vector inside {8'h07, [8'h24:8'h26], [8'h28:8'h2a],
    [8'h34:8'h37], 8'h3c})
    else $error("vector outside table");
  AST_JUMP: assert property (VEC_RD && VEC_ACK |=> JUMP && JUMP_PC == $past(VEC_DATA))
    else $error("handler jump wrong");
  AST_ONEJUMP: assert property (JUMP |=> !JUMP)
    else $error("jump longer than one cycle");
  AST_STEADY: assert property (VEC_INFO.valid && $past(VEC_INFO.valid) |-> $stable(VEC_INFO.vector))
    else $error("vector changed in sequence");
  AST_HOLD: assert property (STK_WR |-> CPU_HOLD && !CPU_IN.retire)
    else $error("push without stall");
  AST_BUS: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
endmodule
bind pic_top pic_top_checker u_pic_top_checker (.*);

// ==== test/tb_top.sv ====
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
module tb_top;
  import pic_pkg::*;
  logic        CLK, RESET_N, NMI_PIN, HWRITE, HSEL, VEC_ACK;
  logic        CPU_HOLD, STK_WR, VEC_RD, JUMP, HREADYOUT, HRESP;
  logic [13:0] SRC_REQ;
  logic [31:0] HADDR, HWDATA, HRDATA, STK_DATA, VEC_DATA, JUMP_PC, seen_pc;
  logic [2:0]  HSIZE;
  logic [1:0]  HTRANS;
  logic [7:0]  seen_vec;
  pic_cpu_t    CPU_IN;
  pic_take_t   VEC_INFO;
  int          failures, check_count, jumps, i;
  localparam logic [7:0] VT [11] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2a, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3c};
  pic_top u_pic_top (.*, .HREADY(HREADYOUT));
  pic_cpu_model u_pic_cpu_model (.clk(CLK), .rst_n(RESET_N), .hold(CPU_HOLD), .vec_rd(VEC_RD), .info(VEC_INFO),
    .jump(JUMP), .cpu(CPU_IN), .vec_ack(VEC_ACK), .vec_data(VEC_DATA));
  always #2 CLK = ~CLK;
  always @(posedge CLK) begin
    if (JUMP === 1'b1) begin
      jumps <= jumps + 1;
      seen_pc <= JUMP_PC;
    end
    if (VEC_RD === 1'b1)
      seen_vec <= VEC_INFO.vector;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= a;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(HRDATA, exp);
  endtask
  task automatic take(input logic [7:0] v);
    int n;
    n = jumps;
    repeat (80) if (jumps == n) @(posedge CLK);
    chk(32'(jumps - n), 32'h1);
    chk({24'h0, seen_vec}, {24'h0, v});
    chk(seen_pc, {16'h8000, 6'h0, v, 2'b00});
  endtask
  task automatic none();
    int n;
    n = jumps;
    repeat (40) @(posedge CLK);
    chk(32'(jumps - n), 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    report_and_stop();
  end
  initial begin
    {CLK, RESET_N, HWRITE, HTRANS, HADDR, HWDATA, SRC_REQ} = '0;
    NMI_PIN = 1'b1;
    HSEL = 1'b1;
    HSIZE = 3'h2;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    rd(32'h0, 32'h1);
    rd(32'h4, 32'h0);
    rd(32'hc, 32'h1);
    rd(32'h20, 32'h0);
    bus(1'b1, 32'h8, 32'h7ff);
    for (i = 0; i < 11; i++) begin
      SRC_REQ <= 14'h1 << i;
      bus(1'b1, 32'hc, 32'h0);
      take(VT[i]);
      SRC_REQ <= 14'h0;
      rd(32'hc, 32'h1);
    end
    bus(1'b1, 32'h8, 32'h7fe);
    SRC_REQ <= 14'h1;
    bus(1'b1, 32'hc, 32'h0);
    none();
    SRC_REQ <= 14'h401;
    take(8'h3c);
    SRC_REQ <= 14'h408;
    bus(1'b1, 32'h8, 32'h7ff);
    bus(1'b1, 32'hc, 32'h0);
    take(8'h28);
    bus(1'b1, 32'h4, 32'h2);
    bus(1'b1, 32'hc, 32'h0);
    take(8'h3c);
    SRC_REQ <= 14'h8;
    bus(1'b1, 32'hc, 32'h0);
    take(8'h28);
    SRC_REQ <= 14'h408;
    none();
    bus(1'b1, 32'hc, 32'h3);
    bus(1'b1, 32'h0, 32'h0);
    none();
    bus(1'b1, 32'hc, 32'h1);
    take(8'h3c);
    rd(32'hc, 32'h3);
    SRC_REQ <= 14'h8;
    bus(1'b1, 32'hc, 32'h1);
    none();
    bus(1'b1, 32'hc, 32'h2);
    take(8'h28);
    SRC_REQ <= 14'h0;
    NMI_PIN <= 1'b0;
    take(8'h07);
    bus(1'b1, 32'h0, 32'h2);
    NMI_PIN <= 1'b1;
    take(8'h07);
    bus(1'b1, 32'hc, 32'h7);
    NMI_PIN <= 1'b0;
    repeat (4) @(posedge CLK);
    NMI_PIN <= 1'b1;
    none();
    bus(1'b1, 32'hc, 32'h3);
    none();
    report_and_stop();
  end
endmodule
